// >>> core/gpel_pkg.sv
package gpel_pkg;
  // ----------------------------------------
  // geometry and reset values
  // ----------------------------------------
  localparam int unsigned NUM_PINS = 32;
  localparam int unsigned PINS_PER_PORT = 8;
  localparam int unsigned EVT_PORTS = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] MUX_RESET = 8'h00;
  localparam logic [7:0] GCFG_RESET = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned BIT_TYPE = 4;
  localparam int unsigned BIT_LOCK = 3;
  localparam int unsigned BIT_MUXLOCK = 7;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] ADDR_SEL = 12'h000;
  localparam logic [11:0] ADDR_CFG = 12'h004;
  localparam logic [11:0] ADDR_MUX = 12'h008;
  localparam logic [11:0] ADDR_GCFG = 12'h00C;
  localparam logic [11:0] ADDR_STAT = 12'h010;
  localparam logic [11:0] ADDR_CLR = 12'h014;
  localparam logic [11:0] ADDR_IEN = 12'h018;
  localparam logic [11:0] ADDR_LEVEL = 12'h01C;
  localparam logic [11:0] ADDR_LOCKED = 12'h020;

  // ----------------------------------------
  // status bits
  // ----------------------------------------
  localparam int unsigned ST_LOCKED = 0;
  localparam int unsigned ST_REFUSED = 1;
  localparam int unsigned ST_MUXLOCKED = 2;
  localparam int unsigned NUM_ST = 3;

  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] data;
  } gpel_req_t;
endpackage

// >>> core/gpel_cfg_cell.sv
`timescale 1ns/1ps
module gpel_cfg_cell #(
  parameter bit HAS_EVT = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] cfg,
  output logic refused
);
  logic [7:0] cfg_q;

  // locked cells refuse writes until reset clears them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= gpel_pkg::CFG_RESET; // RL1
    end else if (wr_en && !cfg_q[gpel_pkg::BIT_LOCK]) begin // RL5
      cfg_q <= wr_data;
      cfg_q[gpel_pkg::BIT_LOCK] <= wr_data[gpel_pkg::BIT_LOCK]; // RL3
      if (!HAS_EVT) begin
        cfg_q[gpel_pkg::BIT_TYPE] <= 1'b0; // RL2
      end
    end
  end

  assign cfg = cfg_q;
  assign refused = wr_en && cfg_q[gpel_pkg::BIT_LOCK];

  chk_lock_sticky: assert property (@(posedge clk) disable iff (!rstn) // RL3
    cfg_q[gpel_pkg::BIT_LOCK] |=> cfg_q[gpel_pkg::BIT_LOCK])
    else $error("lock bit cleared without reset");
  chk_locked_frozen: assert property (@(posedge clk) disable iff (!rstn) // RL5
    cfg_q[gpel_pkg::BIT_LOCK] |=> $stable(cfg_q))
    else $error("locked configuration changed");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rstn) // RL2
    !HAS_EVT |-> !cfg_q[gpel_pkg::BIT_TYPE])
    else $error("reserved type bit set");
endmodule

// >>> core/gpel_top.sv
`timescale 1ns/1ps
// How it works
// RL1: bit 4 selects edge or level, edge default
// RL2: ports 2 and 3 type bit reads zero
// RL3: lock bit sticks until reset
// RL4: mux changeable until global mux lock
// RL5: locked pin ignores configuration writes
module gpel_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] evt_level,
  output logic [31:0] pin_locked,
  output logic [31:0] mux_sel,
  output logic irq
);
  localparam int N = gpel_pkg::NUM_PINS;
  localparam logic [4:0] EVT_PINS = 5'(gpel_pkg::EVT_PORTS * gpel_pkg::PINS_PER_PORT);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  gpel_pkg::gpel_req_t req;
  logic acc;
  logic [4:0] sel_q;
  logic [7:0] cfg [N];
  logic [N-1:0] refused;
  logic [N-1:0] mux_q;
  logic [7:0] gcfg_q;
  logic [gpel_pkg::NUM_ST-1:0] stat_q;
  logic [gpel_pkg::NUM_ST-1:0] ien_q;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic mux_locked;
  logic mapped;

  assign req = '{wr: pwrite, addr: paddr, data: pwdata};
  assign acc = psel && penable;
  assign pready = 1'b1;
  assign mux_locked = gcfg_q[gpel_pkg::BIT_MUXLOCK];

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  always_comb begin
    mapped = 1'b1;
    rdata_d = 32'h0000_0000;
    case (req.addr)
      gpel_pkg::ADDR_SEL: rdata_d = {27'h0, sel_q};
      gpel_pkg::ADDR_CFG: rdata_d = {24'h0, cfg[sel_q]};
      gpel_pkg::ADDR_MUX: rdata_d = mux_q;
      gpel_pkg::ADDR_GCFG: rdata_d = {24'h0, gcfg_q};
      gpel_pkg::ADDR_STAT: rdata_d = {29'h0, stat_q};
      gpel_pkg::ADDR_CLR: rdata_d = 32'h0000_0000;
      gpel_pkg::ADDR_IEN: rdata_d = {29'h0, ien_q};
      gpel_pkg::ADDR_LEVEL: rdata_d = evt_level;
      gpel_pkg::ADDR_LOCKED: rdata_d = pin_locked;
      default: mapped = 1'b0;
    endcase
  end

  // read data is caught in the setup cycle, so prdata comes from a flop with no wait state
  // an event landing in the setup or access cycle of a read shows on the next read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !req.wr) begin
      prdata_q <= rdata_d;
    end else begin
      prdata_q <= 32'h0000_0000;
    end
  end
  assign prdata = prdata_q;
  assign pslverr = acc && !mapped;

  // ----------------------------------------
  // pin index and per-pin cells
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= 5'h00;
    end else if (acc && req.wr && hit(req.addr, gpel_pkg::ADDR_SEL)) begin
      sel_q <= req.data[4:0];
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_pin
    gpel_cfg_cell #(
      .HAS_EVT(i < gpel_pkg::EVT_PORTS * gpel_pkg::PINS_PER_PORT)
    ) u_cell (
      .clk(clk),
      .rstn(rstn),
      .wr_en(acc && req.wr && hit(req.addr, gpel_pkg::ADDR_CFG) && sel_q == 5'(i)),
      .wr_data(req.data[7:0]),
      .cfg(cfg[i]),
      .refused(refused[i])
    );
    assign evt_level[i] = cfg[i][gpel_pkg::BIT_TYPE]; // RL1
    assign pin_locked[i] = cfg[i][gpel_pkg::BIT_LOCK];
  end

  // ----------------------------------------
  // multiplexing and its global lock
  // ----------------------------------------
  // the mux lock is sticky too, else software could unfreeze pin muxing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gcfg_q <= gpel_pkg::GCFG_RESET;
    end else if (acc && req.wr && hit(req.addr, gpel_pkg::ADDR_GCFG)) begin
      gcfg_q <= req.data[7:0] | (gcfg_q & 8'h80);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mux_q <= 32'h0000_0000;
    end else if (acc && req.wr && hit(req.addr, gpel_pkg::ADDR_MUX) && !mux_locked) begin // RL4
      mux_q <= req.data;
    end
  end
  assign mux_sel = mux_q;

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [gpel_pkg::NUM_ST-1:0] ev;
  logic any_lock_q;
  logic mux_lock_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      any_lock_q <= 1'b0;
      mux_lock_q <= 1'b0;
    end else begin
      any_lock_q <= |pin_locked;
      mux_lock_q <= mux_locked;
    end
  end
  assign ev[gpel_pkg::ST_LOCKED] = (|pin_locked) && !any_lock_q;
  assign ev[gpel_pkg::ST_REFUSED] = |refused;
  assign ev[gpel_pkg::ST_MUXLOCKED] = mux_locked && !mux_lock_q;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
    end else if (acc && req.wr && hit(req.addr, gpel_pkg::ADDR_CLR)) begin
      stat_q <= (stat_q & ~req.data[gpel_pkg::NUM_ST-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ien_q <= '0;
    end else if (acc && req.wr && hit(req.addr, gpel_pkg::ADDR_IEN)) begin
      ien_q <= req.data[gpel_pkg::NUM_ST-1:0];
    end
  end

  assign irq = |(stat_q & ien_q);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_mux_frozen: assert property (@(posedge clk) disable iff (!rstn) // RL4
    mux_locked |=> $stable(mux_q))
    else $error("mux changed after global lock");

  chk_mux_open: assert property (@(posedge clk) disable iff (!rstn) // RL4
    acc && req.wr && req.addr == gpel_pkg::ADDR_MUX && !mux_locked
    |=> mux_q == $past(req.data))
    else $error("mux write lost while unlocked");

  chk_mux_sticky: assert property (@(posedge clk) disable iff (!rstn) // RL4
    mux_locked
    |=> mux_locked)
    else $error("global mux lock released");

  chk_mux_lock_set: assert property (@(posedge clk) disable iff (!rstn) // RL4
    acc && req.wr && req.addr == gpel_pkg::ADDR_GCFG && req.data[gpel_pkg::BIT_MUXLOCK]
    |=> mux_locked)
    else $error("global mux lock not set");

  chk_type_out: assert property (@(posedge clk) disable iff (!rstn) // RL1
    acc && req.wr && req.addr == gpel_pkg::ADDR_CFG && sel_q < EVT_PINS && !pin_locked[sel_q]
    |=> evt_level[$past(sel_q)] == $past(req.data[gpel_pkg::BIT_TYPE]))
    else $error("event type not stored");

  chk_hi_type: assert property (@(posedge clk) disable iff (!rstn) // RL2
    evt_level[31:16] == 16'h0000)
    else $error("upper port type bit set");

  chk_type_read: assert property (@(posedge clk) disable iff (!rstn) // RL2
    acc && !req.wr && req.addr == gpel_pkg::ADDR_CFG && sel_q >= EVT_PINS
    |-> !prdata[gpel_pkg::BIT_TYPE])
    else $error("reserved type bit read as one");

  chk_lock_hold: assert property (@(posedge clk) disable iff (!rstn) // RL3
    pin_locked[sel_q] |=> pin_locked[$past(sel_q)])
    else $error("lock released");

  chk_lock_set: assert property (@(posedge clk) disable iff (!rstn) // RL3
    acc && req.wr && req.addr == gpel_pkg::ADDR_CFG && req.data[gpel_pkg::BIT_LOCK]
    |=> pin_locked[$past(sel_q)])
    else $error("lock write not taken");

  chk_refuse_flag: assert property (@(posedge clk) disable iff (!rstn) // RL5
    |refused |=> stat_q[gpel_pkg::ST_REFUSED])
    else $error("refused write not flagged");

  chk_locked_refuse: assert property (@(posedge clk) disable iff (!rstn) // RL5
    acc && req.wr && req.addr == gpel_pkg::ADDR_CFG && pin_locked[sel_q]
    |=> cfg[$past(sel_q)] == $past(cfg[sel_q]))
    else $error("locked pin took a write");
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] evt_level;
  logic [31:0] pin_locked;
  logic [31:0] mux_sel;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] rdat;
  logic err;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  gpel_top DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt_level(evt_level),
    .pin_locked(pin_locked), .mux_sel(mux_sel), .irq(irq));

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // idle edge after each transfer keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, e);
  endtask

  task automatic end_of_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(gpel_pkg::ADDR_CFG, 32'h0, "cfg reset");
    apb(1'b1, gpel_pkg::ADDR_SEL, 32'h3);
    apb(1'b1, gpel_pkg::ADDR_CFG, 32'h10);
    rd(gpel_pkg::ADDR_CFG, 32'h10, "cfg type");
    chk("evt_level", evt_level, 32'h8);
    rd(gpel_pkg::ADDR_LEVEL, 32'h8, "level reg");
    $display("test type done");
    apb(1'b1, gpel_pkg::ADDR_SEL, 32'h14);
    apb(1'b1, gpel_pkg::ADDR_CFG, 32'h10);
    rd(gpel_pkg::ADDR_CFG, 32'h0, "cfg reserved");
    chk("evt_level", evt_level, 32'h8);
    $display("test reserved done");
    apb(1'b1, gpel_pkg::ADDR_SEL, 32'h3);
    apb(1'b1, gpel_pkg::ADDR_CFG, 32'h18);
    apb(1'b1, gpel_pkg::ADDR_CFG, 32'h0);
    rd(gpel_pkg::ADDR_CFG, 32'h18, "cfg locked");
    chk("pin_locked", pin_locked, 32'h8);
    rd(gpel_pkg::ADDR_LOCKED, 32'h8, "locked reg");
    rd(gpel_pkg::ADDR_STAT, 32'h3, "status");
    $display("test lock done");
    apb(1'b1, gpel_pkg::ADDR_MUX, 32'hA5);
    chk("mux_sel", mux_sel, 32'hA5);
    apb(1'b1, gpel_pkg::ADDR_GCFG, 32'h80);
    apb(1'b1, gpel_pkg::ADDR_MUX, 32'h5A);
    chk("mux_sel", mux_sel, 32'hA5);
    rd(gpel_pkg::ADDR_STAT, 32'h7, "status");
    apb(1'b1, gpel_pkg::ADDR_GCFG, 32'h0);
    rd(gpel_pkg::ADDR_GCFG, 32'h80, "gcfg sticky");
    apb(1'b1, gpel_pkg::ADDR_MUX, 32'h5A);
    chk("mux_sel", mux_sel, 32'hA5);
    $display("test mux done");
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, gpel_pkg::ADDR_IEN, 32'h2);
    chk("irq on", {31'h0, irq}, 32'h1);
    apb(1'b1, gpel_pkg::ADDR_CLR, 32'h7);
    rd(gpel_pkg::ADDR_STAT, 32'h0, "status clr");
    chk("irq off", {31'h0, irq}, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    $display("test irq done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("pin_locked", pin_locked, 32'h0);
    apb(1'b1, gpel_pkg::ADDR_SEL, 32'h3);
    apb(1'b1, gpel_pkg::ADDR_CFG, 32'h10);
    rd(gpel_pkg::ADDR_CFG, 32'h10, "cfg after reset");
    apb(1'b1, gpel_pkg::ADDR_MUX, 32'h3C);
    chk("mux_sel", mux_sel, 32'h3C);
    $display("test reset done");
    end_of_test();
  end
endmodule
